// file: include/pieb_pkg.sv
// pieb_pkg: constants shared by the peripheral interrupt enable bank.
// assumes an APB slave with 32-bit data and 12-bit byte addresses.
`default_nettype none
package pieb_pkg;

    // register indices; the byte address is four times the index
    localparam logic [9:0] IDX_GLOBAL_CTRL   = 10'h0a8;
    localparam logic [9:0] IDX_ENABLE_SERIAL = 10'h0a9;
    localparam logic [9:0] IDX_ENABLE_TIMERS = 10'h0aa;
    localparam logic [9:0] IDX_ENABLE_MISC   = 10'h0ab;
    localparam logic [9:0] IDX_EVT_STATUS    = 10'h0c0;
    localparam logic [9:0] IDX_EVT_CLEAR     = 10'h0c1;
    localparam logic [9:0] IDX_EVT_ENABLE    = 10'h0c2;
    localparam logic [9:0] IDX_FWD_LIVE      = 10'h0c3;

    localparam int          ADDR_W     = 12;
    localparam int          SRC_W      = 6;
    localparam int          EVT_W      = 24;

    // enable register fields
    localparam logic [7:0]  ENABLE_RST  = 8'h00;
    localparam logic [7:0]  ENABLE_MASK = 8'h3f;
    localparam int          GLOBAL_BIT  = 7;
    localparam logic        GLOBAL_RST  = 1'b0;

    // event layout: one byte lane per source group
    localparam int          EVT_SERIAL_LSB = 0;
    localparam int          EVT_TIMERS_LSB = 8;
    localparam int          EVT_MISC_LSB   = 16;
    localparam logic [23:0] EVT_RST        = 24'h000000;
    localparam logic [23:0] EVT_MASK       = 24'h3f3f3f;

    // serial group bit positions
    localparam int SER_SERIAL0_RX = 0;
    localparam int SER_SERIAL0_TX = 1;
    localparam int SER_FOUR_WIRE0 = 2;
    localparam int SER_TWO_WIRE   = 3;
    localparam int SER_SERIAL1_RX = 4;
    localparam int SER_SERIAL1_TX = 5;

    // timer group bit positions
    localparam int TMR_ZERO  = 0;
    localparam int TMR_ONE   = 1;
    localparam int TMR_TWO   = 2;
    localparam int TMR_THREE = 3;
    localparam int TMR_FOUR  = 4;
    localparam int TMR_FIVE  = 5;

    // misc group bit positions
    localparam int MSC_CONVERTER      = 0;
    localparam int MSC_NONVOLATILE    = 1;
    localparam int MSC_WATCH_TIMER    = 2;
    localparam int MSC_WATCHDOG       = 3;
    localparam int MSC_INTERVAL_TIMER = 4;
    localparam int MSC_FOUR_WIRE1     = 5;

endpackage : pieb_pkg
`default_nettype wire

// file: logic/pieb_event_bank.sv
// pieb_event_bank: sticky event bits, write-one-to-clear, enable mask and
// one level interrupt output.
// assumes events and strobes come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pieb_event_bank
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [23:0] evt_set,
    input  wire logic        clr_we,
    input  wire logic [23:0] clr_bits,
    input  wire logic        ena_we,
    input  wire logic [23:0] ena_bits,
    output logic      [23:0] status,
    output logic      [23:0] irq_enable,
    output logic             irq
);

    logic [23:0] status_r;
    logic [23:0] status_nxt;
    logic [23:0] ena_r;
    logic [23:0] ena_nxt;
    logic [23:0] clr_mask;
    logic        irq_r;
    logic        irq_nxt;

    assign clr_mask   = clr_we ? clr_bits : pieb_pkg::EVT_RST;
    // a new event in the clear cycle survives: set is applied after clear
    assign status_nxt = ((status_r & ~clr_mask) | evt_set) & pieb_pkg::EVT_MASK;
    assign ena_nxt    = ena_we ? (ena_bits & pieb_pkg::EVT_MASK) : ena_r;
    assign irq_nxt    = |(status_nxt & ena_nxt);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_r <= pieb_pkg::EVT_RST;
            ena_r    <= pieb_pkg::EVT_RST;
            irq_r    <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            ena_r    <= ena_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign status     = status_r;
    assign irq_enable = ena_r;
    assign irq        = irq_r;

endmodule : pieb_event_bank
`default_nettype wire

// file: logic/pieb_enable_bank.sv
// pieb_enable_bank: three source enable registers plus the global enable,
// gating peripheral requests toward priority resolution, with an APB slave.
// assumes requests are synchronous to pclk and held by their sources
// until serviced; priority and vectoring sit downstream.
`timescale 1ns/100ps
`default_nettype none
module pieb_enable_bank
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // raw peripheral requests
    input  wire logic        req_serial1_tx,
    input  wire logic        req_serial1_rx,
    input  wire logic        req_two_wire,
    input  wire logic        req_four_wire0,
    input  wire logic        req_serial0_tx,
    input  wire logic        req_serial0_rx,
    input  wire logic [5:0]  req_timer,
    input  wire logic        req_four_wire1,
    input  wire logic        req_interval_timer,
    input  wire logic        req_watchdog,
    input  wire logic        req_watch_timer,
    input  wire logic        req_nonvolatile_mem,
    input  wire logic        req_converter,
    // gated requests toward priority resolution
    output logic      [5:0]  fwd_serial,
    output logic      [5:0]  fwd_timers,
    output logic      [5:0]  fwd_misc,
    output logic             global_irq_enable,
    output logic             irq
);

    // merge the enabled byte lanes of a write into an old value
    function automatic logic [31:0] lane_merge
    (
        input logic [31:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  strb
    );
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        lane_merge = (old_val & ~m) | (wdata & m);
    endfunction : lane_merge

    // the gate shared by the serial and misc sources
    function automatic logic [5:0] gate_req
    (
        input logic [5:0] req,
        input logic [7:0] en,
        input logic       glb
    );
        gate_req = req & en[5:0] & {6{glb}};
    endfunction : gate_req

    logic [7:0]  en_serial_r;
    logic [7:0]  en_serial_nxt;
    logic [7:0]  en_timers_r;
    logic [7:0]  en_timers_nxt;
    logic [7:0]  en_misc_r;
    logic [7:0]  en_misc_nxt;
    logic        global_r;
    logic        global_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    // named enable fields
    logic        en_serial1_tx;
    logic        en_serial1_rx;
    logic        en_two_wire;
    logic        en_four_wire0;
    logic        en_serial0_tx;
    logic        en_serial0_rx;
    logic        en_timer_zero;
    logic        en_timer_one;
    logic        en_timer_two;
    logic        en_timer_three;
    logic        en_timer_four;
    logic        en_timer_five;
    logic        en_four_wire1;
    logic        en_interval_timer;
    logic        en_watchdog;
    logic        en_watch_timer;
    logic        en_nonvolatile_mem;
    logic        en_converter;

    // bus decode
    logic [9:0]  idx;
    logic        aligned;
    logic        setup_ph;
    logic        access_ph;
    logic        wr_en;
    logic        hit_global;
    logic        hit_serial;
    logic        hit_timers;
    logic        hit_misc;
    logic        hit_status;
    logic        hit_clear;
    logic        hit_evt_en;
    logic        hit_live;
    logic        mapped;
    logic [31:0] wr_merged_global;
    logic [31:0] wr_merged_serial;
    logic [31:0] wr_merged_timers;
    logic [31:0] wr_merged_misc;
    logic [31:0] wr_merged_evt_en;
    logic [31:0] rd_mux;

    // event bank wiring
    logic [5:0]  raw_serial;
    logic [5:0]  raw_misc;
    logic [23:0] evt_set;
    logic [23:0] evt_status;
    logic [23:0] evt_enable;
    logic [23:0] live_fwd;
    logic        clr_we;
    logic        ena_we;

    assign idx       = paddr[11:2];
    assign aligned   = (paddr[1:0] == 2'h0);
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;

    assign hit_global = aligned & (idx == pieb_pkg::IDX_GLOBAL_CTRL);
    assign hit_serial = aligned & (idx == pieb_pkg::IDX_ENABLE_SERIAL);
    assign hit_timers = aligned & (idx == pieb_pkg::IDX_ENABLE_TIMERS);
    assign hit_misc   = aligned & (idx == pieb_pkg::IDX_ENABLE_MISC);
    assign hit_status = aligned & (idx == pieb_pkg::IDX_EVT_STATUS);
    assign hit_clear  = aligned & (idx == pieb_pkg::IDX_EVT_CLEAR);
    assign hit_evt_en = aligned & (idx == pieb_pkg::IDX_EVT_ENABLE);
    assign hit_live   = aligned & (idx == pieb_pkg::IDX_FWD_LIVE);
    assign mapped     = hit_global | hit_serial | hit_timers | hit_misc |
                        hit_status | hit_clear | hit_evt_en | hit_live;

    // zero wait states; unmapped or misaligned accesses end with an error
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign wr_en   = access_ph & pwrite & mapped;

    assign wr_merged_global = lane_merge({24'h000000, global_r, 7'h00}, pwdata, pstrb);
    assign wr_merged_serial = lane_merge({24'h000000, en_serial_r}, pwdata, pstrb);
    assign wr_merged_timers = lane_merge({24'h000000, en_timers_r}, pwdata, pstrb);
    assign wr_merged_misc   = lane_merge({24'h000000, en_misc_r}, pwdata, pstrb);
    assign wr_merged_evt_en = lane_merge({8'h00, evt_enable}, pwdata, pstrb);

    // bits 7..6 of the enable registers never store, so they read as zero
    assign en_serial_nxt = (wr_en & hit_serial)
                         ? (wr_merged_serial[7:0] & pieb_pkg::ENABLE_MASK)
                         : en_serial_r;
    assign en_timers_nxt = (wr_en & hit_timers)
                         ? (wr_merged_timers[7:0] & pieb_pkg::ENABLE_MASK)
                         : en_timers_r;
    assign en_misc_nxt   = (wr_en & hit_misc)
                         ? (wr_merged_misc[7:0] & pieb_pkg::ENABLE_MASK)
                         : en_misc_r;
    assign global_nxt    = (wr_en & hit_global)
                         ? wr_merged_global[pieb_pkg::GLOBAL_BIT]
                         : global_r;

    // clear is write-one; only lanes that are strobed take part
    assign clr_we = wr_en & hit_clear;
    assign ena_we = wr_en & hit_evt_en;

    assign rd_mux = hit_global ? {24'h000000, global_r, 7'h00} :
                    hit_serial ? {24'h000000, en_serial_r} :
                    hit_timers ? {24'h000000, en_timers_r} :
                    hit_misc   ? {24'h000000, en_misc_r} :
                    hit_status ? {8'h00, evt_status} :
                    hit_evt_en ? {8'h00, evt_enable} :
                    hit_live   ? {8'h00, live_fwd} :
                    32'h00000000;

    // read data is captured in the setup cycle so prdata comes from a flop
    assign prdata_nxt = (setup_ph & ~pwrite) ? rd_mux : prdata_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_serial_r <= pieb_pkg::ENABLE_RST;
            en_timers_r <= pieb_pkg::ENABLE_RST;
            en_misc_r   <= pieb_pkg::ENABLE_RST;
            global_r    <= pieb_pkg::GLOBAL_RST;
            prdata_r    <= 32'h00000000;
        end
        else
        begin
            en_serial_r <= en_serial_nxt;
            en_timers_r <= en_timers_nxt;
            en_misc_r   <= en_misc_nxt;
            global_r    <= global_nxt;
            prdata_r    <= prdata_nxt;
        end
    end

    assign prdata            = prdata_r;
    assign global_irq_enable = global_r;

    assign en_serial0_rx      = en_serial_r[pieb_pkg::SER_SERIAL0_RX];
    assign en_serial0_tx      = en_serial_r[pieb_pkg::SER_SERIAL0_TX];
    assign en_four_wire0      = en_serial_r[pieb_pkg::SER_FOUR_WIRE0];
    assign en_two_wire        = en_serial_r[pieb_pkg::SER_TWO_WIRE];
    assign en_serial1_rx      = en_serial_r[pieb_pkg::SER_SERIAL1_RX];
    assign en_serial1_tx      = en_serial_r[pieb_pkg::SER_SERIAL1_TX];
    assign en_timer_zero      = en_timers_r[pieb_pkg::TMR_ZERO];
    assign en_timer_one       = en_timers_r[pieb_pkg::TMR_ONE];
    assign en_timer_two       = en_timers_r[pieb_pkg::TMR_TWO];
    assign en_timer_three     = en_timers_r[pieb_pkg::TMR_THREE];
    assign en_timer_four      = en_timers_r[pieb_pkg::TMR_FOUR];
    assign en_timer_five      = en_timers_r[pieb_pkg::TMR_FIVE];
    assign en_converter       = en_misc_r[pieb_pkg::MSC_CONVERTER];
    assign en_nonvolatile_mem = en_misc_r[pieb_pkg::MSC_NONVOLATILE];
    assign en_watch_timer     = en_misc_r[pieb_pkg::MSC_WATCH_TIMER];
    assign en_watchdog        = en_misc_r[pieb_pkg::MSC_WATCHDOG];
    assign en_interval_timer  = en_misc_r[pieb_pkg::MSC_INTERVAL_TIMER];
    assign en_four_wire1      = en_misc_r[pieb_pkg::MSC_FOUR_WIRE1];

    assign raw_serial = {req_serial1_tx, req_serial1_rx, req_two_wire,
                         req_four_wire0, req_serial0_tx, req_serial0_rx};
    assign raw_misc   = {req_four_wire1, req_interval_timer, req_watchdog,
                         req_watch_timer, req_nonvolatile_mem, req_converter};

    // combinational gate: a request dropped by its source vanishes at once
    assign fwd_serial = gate_req(raw_serial,
                                 {2'h0, en_serial1_tx, en_serial1_rx, en_two_wire,
                                  en_four_wire0, en_serial0_tx, en_serial0_rx},
                                 global_r);
    assign fwd_misc   = gate_req(raw_misc,
                                 {2'h0, en_four_wire1, en_interval_timer, en_watchdog,
                                  en_watch_timer, en_nonvolatile_mem, en_converter},
                                 global_r);
    assign fwd_timers[pieb_pkg::TMR_ZERO]  = req_timer[pieb_pkg::TMR_ZERO]
                                           & en_timer_zero & global_r;
    assign fwd_timers[pieb_pkg::TMR_ONE]   = req_timer[pieb_pkg::TMR_ONE]
                                           & en_timer_one & global_r;
    assign fwd_timers[pieb_pkg::TMR_TWO]   = req_timer[pieb_pkg::TMR_TWO]
                                           & en_timer_two & global_r;
    assign fwd_timers[pieb_pkg::TMR_THREE] = req_timer[pieb_pkg::TMR_THREE]
                                           & en_timer_three & global_r;
    assign fwd_timers[pieb_pkg::TMR_FOUR]  = req_timer[pieb_pkg::TMR_FOUR]
                                           & en_timer_four & global_r;
    assign fwd_timers[pieb_pkg::TMR_FIVE]  = req_timer[pieb_pkg::TMR_FIVE]
                                           & en_timer_five & global_r;

    assign live_fwd = {2'h0, fwd_misc, 2'h0, fwd_timers, 2'h0, fwd_serial};

    // events record raw requests so software can poll sources it has disabled
    assign evt_set = {2'h0, raw_misc, 2'h0, req_timer, 2'h0, raw_serial};

    pieb_event_bank u_events
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .evt_set    (evt_set),
        .clr_we     (clr_we),
        .clr_bits   (pwdata[23:0] & {{8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}}),
        .ena_we     (ena_we),
        .ena_bits   (wr_merged_evt_en[23:0]),
        .status     (evt_status),
        .irq_enable (evt_enable),
        .irq        (irq)
    );

endmodule : pieb_enable_bank
`default_nettype wire

// file: testbench/pieb_enable_bank_asserts.sv
// pieb_enable_bank_asserts: port-level checks of the enable bank.
// assumes a single pclk domain and zero-wait APB slave answers.
`timescale 1ns/100ps
`default_nettype none
module pieb_enable_bank_asserts
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  req_timer,
    input wire logic [5:0]  fwd_serial,
    input wire logic [5:0]  fwd_timers,
    input wire logic [5:0]  fwd_misc,
    input wire logic        global_irq_enable,
    input wire logic        irq
);
    localparam logic [11:0] A_GLB = {pieb_pkg::IDX_GLOBAL_CTRL, 2'b00};
    localparam logic [11:0] A_SER = {pieb_pkg::IDX_ENABLE_SERIAL, 2'b00};
    localparam logic [11:0] A_TMR = {pieb_pkg::IDX_ENABLE_TIMERS, 2'b00};
    localparam logic [11:0] A_MSC = {pieb_pkg::IDX_ENABLE_MISC, 2'b00};
    wire logic acc    = psel && penable && pready;
    wire logic wr_tmr = acc && pwrite && paddr == A_TMR && pstrb[0];
    wire logic wr_glb = acc && pwrite && paddr == A_GLB && pstrb[0];
    wire logic rd_tmr = acc && !pwrite && paddr == A_TMR;
    wire logic rd_en  = acc && !pwrite && (paddr == A_SER || paddr == A_TMR || paddr == A_MSC);
    wire logic mapped = paddr[1:0] == 2'b00 && (paddr[11:4] == 8'h2a || paddr[11:4] == 8'h30);
    // shadow of the timer enables, so gating can be judged without seeing inside
    logic [5:0] sh_tmr_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            sh_tmr_r <= 6'h00;
        else if (wr_tmr)
            sh_tmr_r <= pwdata[5:0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence glb_write_s;
        wr_glb;
    endsequence
    sequence tmr_write_s;
        wr_tmr ##1 (req_timer == 6'h3f && global_irq_enable);
    endsequence

    no_wait_a: assert property (pready)
        else $error("pready dropped");
    global_gate_a: assert property
        (!global_irq_enable |-> fwd_serial == 6'h00 && fwd_timers == 6'h00 && fwd_misc == 6'h00)
        else $error("request passed with global enable clear");
    timer_gate_a: assert property
        (fwd_timers == (req_timer & sh_tmr_r & {6{global_irq_enable}}))
        else $error("timer request gating wrong");
    glb_write_a: assert property
        (glb_write_s |=> global_irq_enable == $past(pwdata[7]))
        else $error("global enable not written");
    tmr_write_a: assert property
        (tmr_write_s |-> fwd_timers == $past(pwdata[5:0]))
        else $error("timer enable write not effective");
    rd_upper_a: assert property
        (rd_en |-> prdata[31:6] == 26'h0)
        else $error("unused enable bits read nonzero");
    rd_timer_a: assert property
        (rd_tmr |-> prdata[5:0] == sh_tmr_r)
        else $error("timer enable read wrong");
    bad_addr_a: assert property
        (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    reset_value_a: assert property
        ($rose(presetn) |-> fwd_timers == 6'h00 && !global_irq_enable && !irq)
        else $error("outputs not cleared by reset");
endmodule : pieb_enable_bank_asserts

bind pieb_enable_bank pieb_enable_bank_asserts u_pieb_enable_bank_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_timer(req_timer), .fwd_serial(fwd_serial),
    .fwd_timers(fwd_timers), .fwd_misc(fwd_misc),
    .global_irq_enable(global_irq_enable), .irq(irq));
`default_nettype wire

// file: testbench/pieb_req_model.sv
// pieb_req_model: peripheral request sources as level requests.
// assumes the bench loads a new request pattern; sources hold it meanwhile.
`timescale 1ns/100ps
`default_nettype none
module pieb_req_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [17:0] pattern,
    output logic      [5:0]  req_serial,
    output logic      [5:0]  req_timer,
    output logic      [5:0]  req_misc
);
    // sources hold their level until told otherwise, as real peripherals do
    logic [17:0] req_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            req_r <= 18'h00000;
        else if (load)
            req_r <= pattern;
    assign {req_misc, req_timer, req_serial} = req_r;
endmodule : pieb_req_model
`default_nettype wire

// file: testbench/tb_top.sv
// tb_top: self-checking bench for the peripheral interrupt enable bank.
// assumes a zero-wait APB slave; reads are scored by a monitor queue.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb_top;
    localparam logic [11:0] A_GLB = {pieb_pkg::IDX_GLOBAL_CTRL, 2'b00};
    localparam logic [11:0] A_SER = {pieb_pkg::IDX_ENABLE_SERIAL, 2'b00};
    localparam logic [11:0] A_TMR = {pieb_pkg::IDX_ENABLE_TIMERS, 2'b00};
    localparam logic [11:0] A_MSC = {pieb_pkg::IDX_ENABLE_MISC, 2'b00};
    localparam logic [11:0] A_STS = {pieb_pkg::IDX_EVT_STATUS, 2'b00};
    localparam logic [11:0] A_CLR = {pieb_pkg::IDX_EVT_CLEAR, 2'b00};
    localparam logic [11:0] A_EEN = {pieb_pkg::IDX_EVT_ENABLE, 2'b00};
    localparam logic [11:0] A_LIV = {pieb_pkg::IDX_FWD_LIVE, 2'b00};
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hf;
    logic        load    = 1'b0;
    logic [17:0] pattern = 18'h00000;
    wire logic [31:0] prdata;
    wire logic        pready, pslverr, global_irq_enable, irq;
    wire logic [5:0]  rq_ser, rq_tmr, rq_msc, fwd_serial, fwd_timers, fwd_misc;
    int          failures   = 0;
    int          num_checks = 0;
    logic [32:0] exp_q[$];
    logic [32:0] ev;
    logic [31:0] e1, e2, e3, g;
    logic [17:0] pat;
    logic [23:0] lv;

    always #4 pclk = ~pclk;

    pieb_req_model u_pieb_req_model (.pclk(pclk), .presetn(presetn), .load(load),
        .pattern(pattern), .req_serial(rq_ser), .req_timer(rq_tmr), .req_misc(rq_msc));
    pieb_enable_bank u_pieb_enable_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_serial1_tx(rq_ser[5]), .req_serial1_rx(rq_ser[4]), .req_two_wire(rq_ser[3]),
        .req_four_wire0(rq_ser[2]), .req_serial0_tx(rq_ser[1]), .req_serial0_rx(rq_ser[0]),
        .req_timer(rq_tmr), .req_four_wire1(rq_msc[5]), .req_interval_timer(rq_msc[4]),
        .req_watchdog(rq_msc[3]), .req_watch_timer(rq_msc[2]),
        .req_nonvolatile_mem(rq_msc[1]), .req_converter(rq_msc[0]),
        .fwd_serial(fwd_serial), .fwd_timers(fwd_timers), .fwd_misc(fwd_misc),
        .global_irq_enable(global_irq_enable), .irq(irq));

    task automatic print_verdict();
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
        exp_q.push_back({err, d});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic drive_req(input logic [17:0] p);
        @(posedge pclk);
        load <= 1'b1;
        pattern <= p;
        @(posedge pclk);
        load <= 1'b0;
    endtask : drive_req

    // read results are taken at the edge that completes the access
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
        begin
            ev = exp_q.pop_front();
            `CHK({pslverr, prdata}, ev)
        end

    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(47173));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_GLB, 32'h0, 1'b0);
        rd(A_SER, 32'h0, 1'b0);
        rd(A_TMR, 32'h0, 1'b0);
        rd(A_MSC, 32'h0, 1'b0);
        rd(12'h2b0, 32'h0, 1'b1);
        rd(12'h2a5, 32'h0, 1'b1);
        // a misaligned write must be refused and leave the serial enables alone
        apb(1'b1, 12'h2a5, 32'h3f);
        rd(A_SER, 32'h0, 1'b0);
        repeat (20)
        begin
            e1 = $urandom();
            e2 = $urandom();
            e3 = $urandom();
            g = $urandom();
            pat = 18'($urandom());
            apb(1'b1, A_SER, e1);
            apb(1'b1, A_TMR, e2);
            apb(1'b1, A_MSC, e3);
            apb(1'b1, A_GLB, g);
            rd(A_SER, e1 & 32'h3f, 1'b0);
            rd(A_TMR, e2 & 32'h3f, 1'b0);
            rd(A_MSC, e3 & 32'h3f, 1'b0);
            rd(A_GLB, g & 32'h80, 1'b0);
            drive_req(pat);
            @(posedge pclk);
            `CHK(fwd_serial, pat[5:0] & e1[5:0] & {6{g[7]}})
            `CHK(fwd_timers, pat[11:6] & e2[5:0] & {6{g[7]}})
            `CHK(fwd_misc, pat[17:12] & e3[5:0] & {6{g[7]}})
            lv = {2'h0, pat[17:12] & e3[5:0], 2'h0, pat[11:6] & e2[5:0],
                  2'h0, pat[5:0] & e1[5:0]} & {24{g[7]}};
            rd(A_LIV, {8'h00, lv}, 1'b0);
        end
        apb(1'b1, A_GLB, 32'h80);
        drive_req(18'h00fc0);
        for (int n = 0; n < 6; n++)
        begin
            apb(1'b1, A_TMR, 32'h1 << n);
            @(posedge pclk);
            `CHK(fwd_timers, 6'h01 << n)
        end
        apb(1'b1, A_GLB, 32'h0);
        apb(1'b1, A_TMR, 32'h3f);
        @(posedge pclk);
        `CHK(fwd_timers, 6'h00)
        // events: clear leftovers, then raise, mask and clear one source
        drive_req(18'h00000);
        apb(1'b1, A_CLR, 32'h3f3f3f);
        apb(1'b1, A_EEN, 32'h100);
        rd(A_STS, 32'h0, 1'b0);
        `CHK(irq, 1'b0)
        drive_req(18'h00040);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        rd(A_STS, 32'h100, 1'b0);
        drive_req(18'h00000);
        apb(1'b1, A_EEN, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, A_CLR, 32'h100);
        rd(A_STS, 32'h0, 1'b0);
        apb(1'b1, A_EEN, 32'h100);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        rd(A_EEN, 32'h100, 1'b0);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
